// ==== rtl/mtpcr_pkg.sv ====
// Constants, field layouts and carrier types of the timer, port and watchdog control bank
// Overview of operation
// R1: Timer prescale select bits 2..0 pick ratios 1:2 up to 1:256, doubling.
// R2: Timer prescale enable bit 3 low gives 1:1, high applies selected ratio.
// R3: External source counts rising pin edges when bit 4 is 0, falling when 1.
// R4: Source bit 5 low counts instruction cycles; pin then ordinary I/O; high counts pin.
// R5: Global enable bit 6 cleared by disable or interrupt entry, set by enable/return.
// R6: Direction bit 0 drives the pin, 1 floats it; port 5 has 7 bits.
// R7: Prescaler readback returns the current down-counting prescaler contents.
// R8: Pull-down bits are active low; bits 0..3 port 5, bits 4..7 port 6.
// R9: Open-drain bits 0..7 map to port 6 pins; 1 enables open-drain.
// R10: Pull-high bits 0..7 map to port 6 pins, active low.
// R11: Watchdog control bit 7 enables the watchdog; writable any time.
// R12: Bit 6 routes port 6 pin 0 to external interrupt, else path masked.
// R13: Software must also make port 6 pin 0 an input for that use.
// R14: Resistor-option bit 4 enables reading option pins port 5 pins 0 and 1.
// R15: Watchdog prescale enable bit 3 low gives 1:1, high applies select.
// R16: Watchdog prescale select bits 2..0 pick ratios 1:2 to 1:256.
// R17: Interrupt mask: bit 0 timer, bit 1 port change, bit 2 external.
// R18: Two separate 8-bit prescalers, one for timer, one for watchdog.
// R19: Any write to the timer count register clears the timer prescaler.
// R20: Watchdog-clear and sleep instructions clear watchdog counter and prescaler.
// R21: Internal timer counts instruction cycles, oscillator over 2 or over 4.
// R22: Watchdog runs in sleep; enabled time-out resets device; about 18 ms.
// R23: Timer overflow sets its interrupt flag; only software clears it.
// R24: Reading interrupt status returns pending flags ANDed with the mask.
// R25: Timer counter wraps from maximum to zero and keeps counting.
package mtpcr_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_TIMER_CONTROL   = 6'h01;
  localparam logic [5:0] IDX_PORT5_DIRECTION = 6'h05;
  localparam logic [5:0] IDX_PORT6_DIRECTION = 6'h06;
  localparam logic [5:0] IDX_PRESCALER_COUNT = 6'h0a;
  localparam logic [5:0] IDX_PULL_DOWN       = 6'h0b;
  localparam logic [5:0] IDX_OPEN_DRAIN      = 6'h0c;
  localparam logic [5:0] IDX_PULL_HIGH       = 6'h0d;
  localparam logic [5:0] IDX_WATCHDOG        = 6'h0e;
  localparam logic [5:0] IDX_INT_MASK        = 6'h0f;
  localparam logic [5:0] IDX_TIMER_COUNT     = 6'h11;
  localparam logic [5:0] IDX_PORT5_DATA      = 6'h15;
  localparam logic [5:0] IDX_PORT6_DATA      = 6'h16;
  localparam logic [5:0] IDX_INT_FLAGS       = 6'h1f;
  localparam logic [5:0] IDX_INSTR_STROBE    = 6'h20;
  localparam logic [5:0] IDX_CLOCK_OPTION    = 6'h21;

  // ------------------------------------------------------------------
  // Strobe bit positions of the instruction register
  // ------------------------------------------------------------------
  localparam int unsigned STB_GLOBAL_ON  = 0;
  localparam int unsigned STB_GLOBAL_OFF = 1;
  localparam int unsigned STB_RETURN     = 2;
  localparam int unsigned STB_INT_ENTRY  = 3;
  localparam int unsigned STB_WDT_CLEAR  = 4;
  localparam int unsigned STB_SLEEP      = 5;

  // ------------------------------------------------------------------
  // Interrupt flag and port bit positions
  // ------------------------------------------------------------------
  localparam int unsigned FLG_TIMER      = 0;
  localparam int unsigned FLG_PORT_CHG   = 1;
  localparam int unsigned FLG_EXTERNAL   = 2;
  localparam int unsigned PIN_TIMER_IN   = 4;
  localparam int unsigned PIN_EXT_INT    = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [6:0] RST_TIMER_CONTROL = 7'h3f;
  localparam logic [6:0] RST_PORT5_DIR     = 7'h7f;
  localparam logic [7:0] RST_PORT6_DIR     = 8'hff;
  localparam logic [7:0] RST_PRESCALER     = 8'hff;
  localparam logic [7:0] RST_WDT_PRESCALER = 8'h00;
  localparam logic [7:0] RST_PULL_DOWN     = 8'hff;
  localparam logic [7:0] RST_OPEN_DRAIN    = 8'h00;
  localparam logic [7:0] RST_PULL_HIGH     = 8'hff;
  localparam logic [7:0] RST_WATCHDOG      = 8'h80;
  localparam logic [2:0] RST_INT_MASK      = 3'h0;
  localparam logic [2:0] RST_INT_FLAGS     = 3'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ     = 250000;
  localparam int unsigned WDT_PERIOD_MS    = 18;
  localparam int unsigned WDT_BASE_CYCLES  = WDT_PERIOD_MS * CLK_FREQ_KHZ;
  localparam logic [1:0]  ICYC_DIV4_LAST   = 2'h3;

  // ------------------------------------------------------------------
  // Register layouts
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       gie;
    logic       src_pin;
    logic       edge_fall;
    logic       pse;
    logic [2:0] sel;
  } mtpcr_tctl_t;

  typedef struct packed {
    logic       wdt_en;
    logic       ext_int_sel;
    logic       unused5;
    logic       roc_en;
    logic       pse;
    logic [2:0] sel;
  } mtpcr_wctl_t;

endpackage

// ==== rtl/mtpcr_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module mtpcr_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// ==== rtl/mtpcr_prescaler.sv ====
// Eight-bit down-counting prescaler with power-of-two ratio select
`timescale 1ns/1ps
module mtpcr_prescaler #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clr_in,
  input  wire logic       event_in,
  input  wire logic       enable_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out,
  output logic      [7:0] count_out
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] mask;
  logic       wrap;

  assign cnt_nxt   = cnt_r - 8'h01;
  assign mask      = 8'hff >> (3'h7 - sel_in);                 // R1 R16
  assign wrap      = (cnt_nxt & mask) == 8'h00;
  // Bypassed prescaler passes every event straight through, except in a clear cycle
  assign tick_out  = event_in & ~clr_in & (~enable_in | wrap);  // R2 R15
  assign count_out = cnt_r;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= RST_VAL;
    end else if (clr_in) begin
      cnt_r <= 8'h00;
    end else if (event_in && enable_in) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== rtl/mtpcr_regs.sv ====
// Timer, port and watchdog control register bank behind an Avalon-MM slave
`timescale 1ns/1ps
module mtpcr_regs
  import mtpcr_pkg::*;
#(
  parameter int unsigned WDT_BASE = WDT_BASE_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [6:0]  port5_in,
  output logic      [6:0]  port5_out,
  output logic      [6:0]  port5_oe_out,
  input  wire logic [7:0]  port6_in,
  output logic      [7:0]  port6_out,
  output logic      [7:0]  port6_oe_out,
  output logic      [3:0]  port5_pull_down_en_out,
  output logic      [3:0]  port6_pull_down_en_out,
  output logic      [7:0]  port6_pull_high_en_out,
  output logic             resistor_option_en_out,
  output logic             int_request_out,
  output logic             wdt_reset_out
);

  // ------------------------------------------------------------------
  // Bus slave: one wait cycle, then the access completes
  // ------------------------------------------------------------------
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        req;
  logic        wr_go;
  logic [5:0]  idx;
  logic        lane0;

  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign wr_go               = avs_write_in & ack_r & lane0;
  assign idx                 = avs_address_in[7:2];
  assign lane0               = avs_byteenable_in[0];
  assign avs_readdata_out    = rdata_r;

  logic wr_tctl, wr_dir5, wr_dir6, wr_pd, wr_od, wr_ph, wr_wctl;
  logic wr_mask, wr_tcc, wr_dat5, wr_dat6, wr_flag, wr_stb, wr_opt;

  assign wr_tctl = wr_go & (idx == IDX_TIMER_CONTROL);
  assign wr_dir5 = wr_go & (idx == IDX_PORT5_DIRECTION);
  assign wr_dir6 = wr_go & (idx == IDX_PORT6_DIRECTION);
  assign wr_pd   = wr_go & (idx == IDX_PULL_DOWN);
  assign wr_od   = wr_go & (idx == IDX_OPEN_DRAIN);
  assign wr_ph   = wr_go & (idx == IDX_PULL_HIGH);
  assign wr_wctl = wr_go & (idx == IDX_WATCHDOG);
  assign wr_mask = wr_go & (idx == IDX_INT_MASK);
  assign wr_tcc  = wr_go & (idx == IDX_TIMER_COUNT);
  assign wr_dat5 = wr_go & (idx == IDX_PORT5_DATA);
  assign wr_dat6 = wr_go & (idx == IDX_PORT6_DATA);
  assign wr_flag = wr_go & (idx == IDX_INT_FLAGS);
  assign wr_stb  = wr_go & (idx == IDX_INSTR_STROBE);
  assign wr_opt  = wr_go & (idx == IDX_CLOCK_OPTION);

  logic [7:0] wd;
  assign wd = avs_writedata_in[7:0];

  // Instruction strobes are one-cycle pulses from a write
  logic stb_on, stb_off, stb_ret, stb_entry, stb_watchdog_clear_instr, stb_sleep;

  assign stb_on    = wr_stb & wd[STB_GLOBAL_ON];
  assign stb_off   = wr_stb & wd[STB_GLOBAL_OFF];
  assign stb_ret   = wr_stb & wd[STB_RETURN];
  assign stb_entry = wr_stb & wd[STB_INT_ENTRY];
  assign stb_watchdog_clear_instr  = wr_stb & wd[STB_WDT_CLEAR];
  assign stb_sleep = wr_stb & wd[STB_SLEEP];

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  mtpcr_tctl_t tctl_r;
  mtpcr_wctl_t wctl_r;
  logic [6:0]  dir5_r, dat5_r;
  logic [7:0]  dir6_r, pd_r, od_r, ph_r, dat6_r;
  logic [2:0]  mask_r;
  logic        clk_opt_r, gie_nxt;

  // Disable wins over enable when both strobes arrive together
  always_comb begin
    gie_nxt = tctl_r.gie;
    if (stb_on || stb_ret) begin
      gie_nxt = 1'b1;                                            // R5
    end
    if (stb_off || stb_entry) begin
      gie_nxt = 1'b0;                                            // R5
    end
    if (wr_tctl) begin
      gie_nxt = wd[6];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tctl_r    <= RST_TIMER_CONTROL;
      wctl_r    <= RST_WATCHDOG;
      dir5_r    <= RST_PORT5_DIR;
      dir6_r    <= RST_PORT6_DIR;
      pd_r      <= RST_PULL_DOWN;
      od_r      <= RST_OPEN_DRAIN;
      ph_r      <= RST_PULL_HIGH;
      mask_r    <= RST_INT_MASK;
      dat5_r    <= 7'h00;
      dat6_r    <= 8'h00;
      clk_opt_r <= 1'b0;
    end else begin
      if (wr_tctl) tctl_r <= wd[6:0];                           // R1 R2 R3 R4
      tctl_r.gie <= gie_nxt;
      if (wr_wctl) wctl_r <= {wd[7:6], 1'b0, wd[4:0]};          // R11 R12 R14 R15
      if (wr_dir5) dir5_r <= wd[6:0];                           // R6
      if (wr_dir6) dir6_r <= wd;
      if (wr_pd)   pd_r   <= wd;
      if (wr_od)   od_r   <= wd;
      if (wr_ph)   ph_r   <= wd;
      if (wr_mask) mask_r <= wd[2:0];                           // R17
      if (wr_dat5) dat5_r <= wd[6:0];
      if (wr_dat6) dat6_r <= wd;
      if (wr_opt)  clk_opt_r <= wd[0];
    end
  end

  // ------------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------------
  logic [6:0] p5_s, p5_drive;
  logic [7:0] p6_s, p6_prev_r;
  logic       tpin_prev_r;

  mtpcr_sync #(.W(7)) u_sync5 (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (port5_in),
    .q_out      (p5_s)
  );

  mtpcr_sync #(.W(8)) u_sync6 (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .d_in       (port6_in),
    .q_out      (p6_s)
  );

  assign p5_drive = ~dir5_r;                                     // R6
  // Timer input pin stops being an I/O pin while it clocks the timer
  assign port5_oe_out = p5_drive & ~(7'(tctl_r.src_pin) << PIN_TIMER_IN);  // R4
  assign port5_out    = dat5_r;
  assign port6_out    = dat6_r;
  // Open-drain pins only pull low; a high bit floats the pin
  assign port6_oe_out = ~dir6_r & (~od_r | ~dat6_r);             // R6 R9
  assign port5_pull_down_en_out = ~pd_r[3:0];                    // R8
  assign port6_pull_down_en_out = ~pd_r[7:4];                    // R8
  assign port6_pull_high_en_out = ~ph_r;                         // R10
  assign resistor_option_en_out = wctl_r.roc_en;                 // R14

  // ------------------------------------------------------------------
  // Timer path
  // ------------------------------------------------------------------
  logic [1:0] div_r;
  logic [2:0] prime_r;
  logic       icyc_en, tpin, pin_evt, cnt_evt, tmr_tick, tcc_ovf, armed;
  logic [7:0] tcc_r, tpsc_cnt;

  assign icyc_en = clk_opt_r ? (div_r == ICYC_DIV4_LAST) : div_r[0];    // R21
  assign tpin    = p5_s[PIN_TIMER_IN];
  // Edge detectors wait until the synchronisers hold real pin levels
  assign armed   = prime_r[2];
  assign pin_evt = armed & (tctl_r.edge_fall ? (tpin_prev_r & ~tpin)
                                             : (~tpin_prev_r & tpin)); // R3
  assign cnt_evt = tctl_r.src_pin ? pin_evt : icyc_en;                 // R4 R21
  assign tcc_ovf = tmr_tick & (tcc_r == 8'hff) & ~wr_tcc;

  mtpcr_prescaler #(.RST_VAL(RST_PRESCALER)) u_tmr_psc (             // R18
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .clr_in     (wr_tcc),                                            // R19
    .event_in   (cnt_evt),
    .enable_in  (tctl_r.pse),
    .sel_in     (tctl_r.sel),
    .tick_out   (tmr_tick),
    .count_out  (tpsc_cnt)
  );

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_r       <= 2'h0;
      prime_r     <= 3'h0;
      tcc_r       <= 8'h00;
      tpin_prev_r <= 1'b0;
      p6_prev_r   <= 8'h00;
    end else begin
      div_r       <= div_r + 2'h1;
      prime_r     <= {prime_r[1:0], 1'b1};
      tpin_prev_r <= tpin;
      p6_prev_r   <= p6_s;
      if (wr_tcc) begin
        tcc_r <= wd;
      end else if (tmr_tick) begin
        tcc_r <= tcc_r + 8'h01;                                  // R25
      end
    end
  end

  // ------------------------------------------------------------------
  // Watchdog: base period from a cycle count, then its own prescaler
  // ------------------------------------------------------------------
  logic [31:0] wdt_cnt_r;
  logic        wdt_clr, wdt_base_tick, wdt_timeout;
  logic [7:0]  wpsc_cnt;

  assign wdt_clr       = stb_watchdog_clear_instr | stb_sleep;                   // R20
  assign wdt_base_tick = ~wdt_clr & (wdt_cnt_r == 32'(WDT_BASE - 1));

  mtpcr_prescaler #(.RST_VAL(RST_WDT_PRESCALER)) u_wdt_psc (         // R18
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .clr_in     (wdt_clr),                                           // R20
    .event_in   (wdt_base_tick),
    .enable_in  (wctl_r.pse),
    .sel_in     (wctl_r.sel),
    .tick_out   (wdt_timeout),
    .count_out  (wpsc_cnt)
  );

  // Counting goes on in sleep; only enable gates the reset request
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wdt_cnt_r     <= 32'h0;
      wdt_reset_out <= 1'b0;
    end else begin
      if (wdt_clr || wdt_base_tick) begin
        wdt_cnt_r <= 32'h0;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + 32'h1;                          // R22
      end
      wdt_reset_out <= wdt_timeout & wctl_r.wdt_en;              // R11 R22
    end
  end

  // ------------------------------------------------------------------
  // Interrupt flags: hardware set beats software clear
  // ------------------------------------------------------------------
  logic [2:0] flags_r, flag_set, flag_keep;
  logic       ext_pin, ext_prev;

  assign ext_pin  = p6_s[PIN_EXT_INT];
  assign ext_prev = p6_prev_r[PIN_EXT_INT];
  assign flag_set[FLG_TIMER]    = tcc_ovf;                       // R23
  assign flag_set[FLG_PORT_CHG] = armed & (p6_s != p6_prev_r);
  // Masked path: no external flag unless the pin is routed to it
  assign flag_set[FLG_EXTERNAL] = armed & wctl_r.ext_int_sel & ext_prev & ~ext_pin; // R12
  assign flag_keep = wr_flag ? (flags_r & wd[2:0]) : flags_r;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_r <= RST_INT_FLAGS;
    end else begin
      flags_r <= flag_keep | flag_set;                           // R23
    end
  end

  assign int_request_out = tctl_r.gie & |(flags_r & mask_r);      // R17

  // ------------------------------------------------------------------
  // Read mux, latched in the wait cycle
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (idx)
      IDX_TIMER_CONTROL:   rd_mux = {1'b0, tctl_r};
      IDX_PORT5_DIRECTION: rd_mux = {1'b0, dir5_r};              // R6
      IDX_PORT6_DIRECTION: rd_mux = dir6_r;
      IDX_PRESCALER_COUNT: rd_mux = tpsc_cnt;                    // R7
      IDX_PULL_DOWN:       rd_mux = pd_r;
      IDX_OPEN_DRAIN:      rd_mux = od_r;
      IDX_PULL_HIGH:       rd_mux = ph_r;
      IDX_WATCHDOG:        rd_mux = wctl_r;
      IDX_INT_MASK:        rd_mux = {5'h00, mask_r};
      IDX_TIMER_COUNT:     rd_mux = tcc_r;
      IDX_PORT5_DATA:      rd_mux = {1'b0, p5_s};                // R14
      IDX_PORT6_DATA:      rd_mux = p6_s;                        // R12
      IDX_INT_FLAGS:       rd_mux = {5'h00, flags_r & mask_r};   // R24
      IDX_CLOCK_OPTION:    rd_mux = {7'h00, clk_opt_r};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read_in && !ack_r) begin
        rdata_r <= {24'h000000, rd_mux};
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_tmr_ovf_flag;
    @(posedge mclk_in) disable iff (sys_rst_in)
    tcc_ovf |=> flags_r[FLG_TIMER] && (tcc_r == 8'h00);
  endproperty
  a_tmr_ovf_flag: assert property (p_tmr_ovf_flag) else $error("overflow lost"); // R23
  property p_psc_clear;
    @(posedge mclk_in) disable iff (sys_rst_in)
    wr_tcc |=> (tpsc_cnt == 8'h00) && (tcc_r == $past(wd));
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("timer prescaler not cleared"); // R19
  property p_wdt_clear;
    @(posedge mclk_in) disable iff (sys_rst_in)
    wdt_clr |=> (wdt_cnt_r == 32'h0) && (wpsc_cnt == 8'h00);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // R20
  property p_gie_off;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (stb_off || stb_entry) |=> !tctl_r.gie ##1 !int_request_out;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("global enable stayed on"); // R5
  property p_bypass_rate;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (!tctl_r.pse && cnt_evt && !wr_tcc) |=> tcc_r == 8'($past(tcc_r) + 8'h01);
  endproperty
  a_bypass_rate: assert property (p_bypass_rate) else $error("1:1 rate broken"); // R2
  property p_status_read;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (avs_read_in && !ack_r && idx == IDX_INT_FLAGS)
      |=> !avs_waitrequest_out && avs_readdata_out[2:0] == $past(flags_r & mask_r);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read not masked"); // R24
  property p_pin_source;
    @(posedge mclk_in) disable iff (sys_rst_in)
    tctl_r.src_pin |-> !port5_oe_out[PIN_TIMER_IN];
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("timer pin driven"); // R4
  property p_wdt_off;
    @(posedge mclk_in) disable iff (sys_rst_in)
    !wctl_r.wdt_en ##1 !wctl_r.wdt_en |-> !wdt_reset_out;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog fired"); // R11
  property p_ext_masked;
    @(posedge mclk_in) disable iff (sys_rst_in)
    (!wctl_r.ext_int_sel && !flags_r[FLG_EXTERNAL] && !wr_flag) |=> !flags_r[FLG_EXTERNAL];
  endproperty
  a_ext_masked: assert property (p_ext_masked) else $error("masked ext path set flag"); // R12

  c_overflow:  cover property (@(posedge mclk_in) tcc_ovf);
  c_wdt_reset: cover property (@(posedge mclk_in) wdt_reset_out);
  c_stat_read: cover property (@(posedge mclk_in) avs_read_in && ack_r && idx == IDX_INT_FLAGS);
  c_ext_flag:  cover property (@(posedge mclk_in) flag_set[FLG_EXTERNAL]);

endmodule

// ==== bench/mtpcr_pin_model.sv ====
// Pin-side model of port 6: resolves each wire from drive enables and pulls
`timescale 1ns/1ps
module mtpcr_pin_model (
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pull_high_in,
  input  wire logic [7:0] ext_level_in,
  output logic      [7:0] pin_out
);
  // Driven pins win; a pulled-up floating pin reads high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_out[i] = oe_in[i] ? drv_in[i] : (pull_high_in[i] | ext_level_in[i]);
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench of the control register bank
`timescale 1ns/1ps
module tb_top;
  import mtpcr_pkg::*;
  typedef struct packed {logic [5:0] idx; logic wr; logic [7:0] d; logic [7:0] e;} mtpcr_row_t;
  logic mclk_in = 0, sys_rst_in = 1, rd = 0, wr = 0, irq, wdt;
  logic [7:0] addr = 0, q, p6_in, p6_out, p6_oe, ph_en, ext = 8'hff;
  logic [31:0] wdata = 0, rdata;
  logic [6:0] p5_oe;
  logic [3:0] pd5, pd6;
  logic waitreq, resistor_option_read_enable;
  int fail_count = 0, comparisons = 0;
  mtpcr_row_t rows[20] = '{
    '{IDX_TIMER_CONTROL, 0, 0, 8'h3f}, '{IDX_PORT5_DIRECTION, 0, 0, 8'h7f},
    '{IDX_PORT6_DIRECTION, 0, 0, 8'hff}, '{IDX_PRESCALER_COUNT, 0, 0, 8'hff},
    '{IDX_PULL_DOWN, 0, 0, 8'hff}, '{IDX_OPEN_DRAIN, 0, 0, 8'h00},
    '{IDX_PULL_HIGH, 0, 0, 8'hff}, '{IDX_WATCHDOG, 0, 0, 8'h80},
    '{IDX_INT_MASK, 0, 0, 8'h00}, '{IDX_TIMER_CONTROL, 1, 8'hff, 8'h7f},
    '{IDX_PORT5_DIRECTION, 1, 8'hff, 8'h7f}, '{IDX_PORT6_DIRECTION, 1, 8'h01, 8'h01},
    '{IDX_PULL_DOWN, 1, 8'h5a, 8'h5a}, '{IDX_OPEN_DRAIN, 1, 8'h3c, 8'h3c},
    '{IDX_PULL_HIGH, 1, 8'hc3, 8'hc3}, '{IDX_WATCHDOG, 1, 8'hff, 8'hdf},
    '{IDX_INT_MASK, 1, 8'hff, 8'h07}, '{IDX_PRESCALER_COUNT, 1, 8'h12, 8'hff},
    '{6'h08, 1, 8'h55, 8'h00}, '{IDX_INT_MASK, 1, 8'h01, 8'h01}};
  // ----------------------------------------
  // Clock, design and pin model
  // ----------------------------------------
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  mtpcr_regs #(.WDT_BASE(20)) u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .port5_in(7'h00), .port5_out(), .port5_oe_out(p5_oe), .port6_in(p6_in),
    .port6_out(p6_out), .port6_oe_out(p6_oe), .port5_pull_down_en_out(pd5),
    .port6_pull_down_en_out(pd6), .port6_pull_high_en_out(ph_en),
    .resistor_option_en_out(resistor_option_read_enable), .int_request_out(irq), .wdt_reset_out(wdt));
  mtpcr_pin_model u_pins (.drv_in(p6_out), .oe_in(p6_oe), .pull_high_in(ph_en),
    .ext_level_in(ext), .pin_out(p6_in));
  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk_in);
    end while (waitreq !== 1'b0);
    q = rdata[7:0];
    rd <= 0;
    wr <= 0;
    @(posedge mclk_in);
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic count_wdt(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (100) begin
      @(posedge mclk_in);
      n = n + {7'h0, wdt};
    end
    check("watchdog resets", n, exp);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 0;
    @(posedge mclk_in);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(rows[i].idx, 1, rows[i].d);
      bus(rows[i].idx, 0, 0);
      check("register", q, rows[i].e);
    end
    check("port6 drive", p6_oe, 8'hfe);
    check("port5 drive", {1'b0, p5_oe}, 8'h00);
    check("pull down", {pd6, pd5}, 8'ha5);
    check("pull high", ph_en, 8'h3c);
    check("r option", {7'h0, resistor_option_read_enable}, 8'h01);
    bus(IDX_INT_MASK, 1, 8'h04);
    ext <= 8'hfe;
    repeat (6) @(posedge mclk_in);
    bus(IDX_INT_FLAGS, 0, 0);
    check("ext flag", q, 8'h04);
    bus(IDX_INT_MASK, 1, 8'h01);
    bus(IDX_TIMER_CONTROL, 1, 8'h00);
    bus(IDX_TIMER_COUNT, 1, 8'hfe);
    repeat (20) @(posedge mclk_in);
    bus(IDX_INT_FLAGS, 0, 0);
    check("flags", q, 8'h01);
    check("irq off", {7'h0, irq}, 8'h00);
    bus(IDX_INSTR_STROBE, 1, 8'h01);
    check("irq on", {7'h0, irq}, 8'h01);
    bus(IDX_INSTR_STROBE, 1, 8'h02);
    check("irq masked", {7'h0, irq}, 8'h00);
    bus(IDX_WATCHDOG, 1, 8'h80);
    bus(IDX_INSTR_STROBE, 1, 8'h30);
    count_wdt(8'h05);
    bus(IDX_WATCHDOG, 1, 8'h00);
    count_wdt(8'h00);
    sys_rst_in <= 1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 0;
    @(posedge mclk_in);
    bus(IDX_WATCHDOG, 0, 0);
    check("reset", q, 8'h80);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    give_verdict();
  end
endmodule
